//--- freeze_cfg.svh
// timing and level constants for the freeze entry/exit control pair
// assumes a 250 MHz core clock on both ends
`ifndef FREEZE_CFG_SVH
`define FREEZE_CFG_SVH

`define CLK_PERIOD_NS       4
`define OUT_LAG_NS          200
`define OUT_LAG_CYC         (`OUT_LAG_NS / `CLK_PERIOD_NS)
`define OUT_LAG_W           6
`define IO_W                8
`define FROZEN_LEVEL        1'b1
`define SETTLE_CYC          4
`define SETTLE_W            3

`endif

//--- freeze_pkg.sv
// types shared by the device end and the management end
// assumes freeze_cfg.svh is on the include path
`default_nettype none

package freeze_pkg;
  typedef enum logic [1:0] {
    DEV_ACTIVE,
    DEV_FROZEN,
    DEV_EXIT
  } dev_state_type;

  typedef enum logic [2:0] {
    MGT_RUN,
    MGT_HOUSEKEEP,
    MGT_GATE,
    MGT_ALLOW,
    MGT_WAIT_OUT,
    MGT_UNGATE
  } mgt_state_type;
endpackage : freeze_pkg

`default_nettype wire

//--- freeze_if.sv
// link between the device freeze block and user freeze management logic
// assumes both ends share core_clk_i
`default_nettype none
`include "freeze_cfg.svh"

interface freeze_if;
  logic              freeze_pin_allow;
  logic              freeze_pin;
  logic              frozen;
  logic              inputs_en;
  logic              outputs_en;
  logic              self_rst_pin;
  logic [`IO_W-1:0]  user_out;

  modport device (
    input  freeze_pin_allow,
    input  freeze_pin,
    input  user_out,
    output frozen,
    output inputs_en,
    output outputs_en,
    output self_rst_pin
  );

  modport mgmt (
    output freeze_pin_allow,
    output user_out,
    input  frozen,
    input  inputs_en,
    input  outputs_en,
    input  self_rst_pin
  );
endinterface : freeze_if

`default_nettype wire

//--- low_static_access_macro.sv
// How it works
// - frozen I/Os and globals read high
// - allow low blocks the freeze pin
// - freeze request is allow AND pin
// - user keeps allow high through freeze
// - inputs enable first, outputs 200 ns later
// - test state machine holds while frozen
// - self-reset pin falls on freeze exit
// - user wires active-high pulled-up self reset
// - user prefers active-low top-level reset
// - drivers release inputs only once frozen
// - async in-to-out paths latched before entry
// - test clock held static while frozen
// - registers and memory kept across freeze
// - system clocks gated cleanly around freeze
//
// device end of the freeze link: entry, exit stagger and pin levels
// assumes freeze pin and allow are synchronous to core_clk_i
`default_nettype none
`include "freeze_cfg.svh"

module low_static_access_macro
  import freeze_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  freeze_if.device               link,
  input  wire logic [`IO_W-1:0]  pad_in_i,
  input  wire logic              tck_i,
  input  wire logic              tms_i,
  output logic      [`IO_W-1:0]  pad_out_o,
  output logic      [`IO_W-1:0]  core_in_o,
  output logic                   global_o,
  output logic      [3:0]        tap_state_o
);

  dev_state_type          state_ff;
  logic [`OUT_LAG_W-1:0]  lag_ff;
  logic                   frozen_ff;
  logic                   in_en_ff;
  logic                   out_en_ff;
  logic                   self_rst_ff;
  logic                   tck_q_ff;
  logic                   freeze_req;
  logic [3:0]             nxt_tap;
  logic                   tck_rise;

  assign freeze_req = link.freeze_pin_allow & link.freeze_pin;

  // ----------------------------------------------------------------
  // entry / exit sequencing
  // ----------------------------------------------------------------
  // exit waits the full output lag, the worst case the user must cover
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_ff <= DEV_ACTIVE;
      lag_ff   <= '0;
    end else begin
      case (state_ff)
        DEV_ACTIVE: begin
          if (freeze_req) begin
            state_ff <= DEV_FROZEN;
          end
        end
        DEV_FROZEN: begin
          if (!freeze_req) begin
            state_ff <= DEV_EXIT;
            lag_ff   <= '0;
          end
        end
        DEV_EXIT: begin
          // a new request waits here; exit always runs to its end
          if (lag_ff == `OUT_LAG_W'(`OUT_LAG_CYC - 1)) begin
            state_ff <= DEV_ACTIVE;
          end else begin
            lag_ff <= lag_ff + 1'b1;
          end
        end
        default: begin
          state_ff <= DEV_ACTIVE;
        end
      endcase
    end
  end

  // enables trail the state by one edge so the link only carries flops
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      frozen_ff <= 1'b0;
      in_en_ff  <= 1'b1;
      out_en_ff <= 1'b1;
    end else begin
      frozen_ff <= (state_ff == DEV_FROZEN);
      in_en_ff  <= (state_ff != DEV_FROZEN);
      out_en_ff <= (state_ff == DEV_ACTIVE);
    end
  end

  // ----------------------------------------------------------------
  // pad levels
  // ----------------------------------------------------------------
  // frozen pads and globals read high; core input regs keep last value
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pad_out_o <= {`IO_W{`FROZEN_LEVEL}};
      global_o  <= `FROZEN_LEVEL;
    end else if (!out_en_ff) begin
      pad_out_o <= {`IO_W{`FROZEN_LEVEL}};
      global_o  <= `FROZEN_LEVEL;
    end else begin
      pad_out_o <= link.user_out;
      global_o  <= 1'b0;
    end
  end

  // pads are sampled only while enabled; a frozen pad never reaches core
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      core_in_o <= '0;
    end else if (in_en_ff) begin
      core_in_o <= pad_in_i;
    end // else held
  end

  // self-reset pin: pulled up while frozen, driven low when active
  // it falls one edge after inputs return, long before outputs do
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      self_rst_ff <= 1'b0;
    end else begin
      self_rst_ff <= !in_en_ff;
    end
  end

  // ----------------------------------------------------------------
  // test state machine: powered but frozen in place
  // ----------------------------------------------------------------
  // state codes are a local choice; the walk between them is standard
  localparam logic [3:0] TAP_RESET    = 4'hF;
  localparam logic [3:0] TAP_IDLE     = 4'hC;
  localparam logic [3:0] TAP_SEL_DR   = 4'h7;
  localparam logic [3:0] TAP_CAP_DR   = 4'h6;
  localparam logic [3:0] TAP_SHIFT_DR = 4'h2;
  localparam logic [3:0] TAP_EXIT1_DR = 4'h1;
  localparam logic [3:0] TAP_PAUSE_DR = 4'h3;
  localparam logic [3:0] TAP_EXIT2_DR = 4'h0;
  localparam logic [3:0] TAP_UPD_DR   = 4'h5;
  localparam logic [3:0] TAP_SEL_IR   = 4'h4;
  localparam logic [3:0] TAP_CAP_IR   = 4'hE;
  localparam logic [3:0] TAP_SHIFT_IR = 4'hA;
  localparam logic [3:0] TAP_EXIT1_IR = 4'h9;
  localparam logic [3:0] TAP_PAUSE_IR = 4'hB;
  localparam logic [3:0] TAP_EXIT2_IR = 4'h8;
  localparam logic [3:0] TAP_UPD_IR   = 4'hD;

  // tck sampled as a level; only its rising edge advances the state
  assign tck_rise = tck_i && !tck_q_ff;

  // next state from tms alone; the flop below decides whether to take it
  always_comb begin
    nxt_tap = tap_state_o;
    case (tap_state_o)
      TAP_RESET:    nxt_tap = tms_i ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     nxt_tap = tms_i ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   nxt_tap = tms_i ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   nxt_tap = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: nxt_tap = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: nxt_tap = tms_i ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: nxt_tap = tms_i ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: nxt_tap = tms_i ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   nxt_tap = tms_i ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   nxt_tap = tms_i ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   nxt_tap = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: nxt_tap = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: nxt_tap = tms_i ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: nxt_tap = tms_i ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: nxt_tap = tms_i ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   nxt_tap = tms_i ? TAP_SEL_DR   : TAP_IDLE;
      default:      nxt_tap = TAP_RESET;
    endcase
  end

  // a stray tck edge while frozen is dropped, so the tap never moves
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tck_q_ff    <= 1'b0;
      tap_state_o <= TAP_RESET;
    end else begin
      tck_q_ff <= tck_i;
      if (tck_rise && !frozen_ff) begin
        tap_state_o <= nxt_tap;
      end
    end
  end

  // ----------------------------------------------------------------
  // link outputs
  // ----------------------------------------------------------------
  // every link signal is a flop, so the far end never sees a glitch
  assign link.frozen       = frozen_ff;
  assign link.inputs_en    = in_en_ff;
  assign link.outputs_en   = out_en_ff;
  assign link.self_rst_pin = self_rst_ff;

endmodule : low_static_access_macro

`default_nettype wire

//--- freeze_mgmt.sv
// user-side freeze management: clock gating, housekeeping, allow control
// assumes the device end sits on the other side of freeze_if
`default_nettype none
`include "freeze_cfg.svh"

module freeze_mgmt
  import freeze_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  freeze_if.mgmt                 link,
  input  wire logic              freeze_want_i,
  input  wire logic              housekeep_done_i,
  input  wire logic [`IO_W-1:0]  async_in_i,
  output logic                   clk_en_o,
  output logic                   housekeep_req_o,
  output logic      [`IO_W-1:0]  async_out_o,
  output logic                   user_rst_n_o,
  output logic                   tck_hold_o
);

  mgt_state_type          state_ff;
  logic [`SETTLE_W-1:0]   settle_ff;
  logic                   allow_ff;
  logic                   latch_ff;

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_ff  <= MGT_RUN;
      settle_ff <= '0;
    end else begin
      case (state_ff)
        MGT_RUN: begin
          if (freeze_want_i) begin
            state_ff <= MGT_HOUSEKEEP;
          end
        end
        MGT_HOUSEKEEP: begin
          if (housekeep_done_i) begin
            state_ff  <= MGT_GATE;
            settle_ff <= '0;
          end
        end
        MGT_GATE: begin
          // let the gated clock settle before allowing entry
          if (settle_ff == `SETTLE_W'(`SETTLE_CYC - 1)) begin
            state_ff <= MGT_ALLOW;
          end else begin
            settle_ff <= settle_ff + 1'b1;
          end
        end
        MGT_ALLOW: begin
          if (link.frozen && !freeze_want_i) begin
            state_ff <= MGT_WAIT_OUT;
          end
        end
        MGT_WAIT_OUT: begin
          if (link.outputs_en) begin
            state_ff <= MGT_UNGATE;
          end
        end
        MGT_UNGATE: begin
          state_ff <= MGT_RUN;
        end
        default: begin
          state_ff <= MGT_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // allow stays high through entry and freeze; drop only once exited
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      allow_ff <= 1'b0;
    end else begin
      allow_ff <= (state_ff == MGT_ALLOW) ||
                  (state_ff == MGT_WAIT_OUT && link.frozen);
    end
  end

  // clock enable changes only from a flop, so the gate never runts
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      clk_en_o        <= 1'b1;
      housekeep_req_o <= 1'b0;
      latch_ff        <= 1'b0;
      tck_hold_o      <= 1'b0;
    end else begin
      clk_en_o        <= (state_ff == MGT_RUN) ||
                         (state_ff == MGT_HOUSEKEEP) ||
                         (state_ff == MGT_UNGATE);
      housekeep_req_o <= (state_ff == MGT_HOUSEKEEP);
      latch_ff        <= (state_ff != MGT_RUN) &&
                         (state_ff != MGT_HOUSEKEEP);
      tck_hold_o      <= (state_ff == MGT_ALLOW) ||
                         (state_ff == MGT_WAIT_OUT);
    end
  end

  // async in-to-out path frozen at last value before entry
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      async_out_o <= '0;
    end else if (!latch_ff) begin
      async_out_o <= async_in_i;
    end
  end

  // self-reset pin is high while frozen; present it active low
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      user_rst_n_o <= 1'b0;
    end else begin
      user_rst_n_o <= !link.self_rst_pin;
    end
  end

  assign link.freeze_pin_allow = allow_ff;
  assign link.user_out         = async_out_o;

endmodule : freeze_mgmt

`default_nettype wire

//--- freeze_assertions.sv
// concurrent checks on the freeze link between the two design ends
// assumes the freeze_if signals and the shared clock and reset as inputs
`default_nettype none

module freeze_assertions (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic freeze_pin_allow,
  input wire logic freeze_pin,
  input wire logic frozen,
  input wire logic inputs_en,
  input wire logic outputs_en,
  input wire logic self_rst_pin
);
  // ------------------------------------------------------------
  // entry
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_NO_BLOCKED_ENTRY :
    assert property ($rose(frozen) |-> $past(freeze_pin_allow && freeze_pin, 2))
    else $error("frozen without an allowed freeze pin");
  AST_ENTRY_TWO :
    assert property (freeze_pin_allow && freeze_pin && outputs_en && !frozen
                     |-> ##2 frozen)
    else $error("allowed request did not freeze in two cycles");
  AST_FROZEN_OFF :
    assert property ($rose(frozen) |-> !inputs_en && !outputs_en)
    else $error("pins still enabled on freeze");
  AST_STAY_FROZEN :
    assert property (frozen && freeze_pin_allow && freeze_pin |=> frozen)
    else $error("left freeze while request held");
  AST_ALLOW_HELD :
    assert property (frozen |-> freeze_pin_allow)
    else $error("allow dropped while frozen");
  // ------------------------------------------------------------
  // exit stagger
  // ------------------------------------------------------------
  AST_EXIT_INPUTS :
    assert property (frozen && $fell(freeze_pin_allow && freeze_pin)
                     |-> ##2 inputs_en)
    else $error("inputs not enabled two cycles after exit");
  AST_OUT_LAG :
    assert property ($rose(inputs_en) |-> ##50 $rose(outputs_en))
    else $error("outputs not enabled fifty cycles after inputs");
  AST_OUT_LATE :
    assert property ($rose(inputs_en) |-> !outputs_en [*8])
    else $error("outputs enabled too early");
  AST_IN_FIRST :
    assert property (outputs_en |-> inputs_en)
    else $error("outputs enabled ahead of inputs");
  AST_SELF_RST :
    assert property ($rose(inputs_en) |=> $fell(self_rst_pin))
    else $error("self reset pin did not fall after exit");
endmodule : freeze_assertions

`default_nettype wire

//--- tb_top.sv
// freeze round trips through the device end and the management end
// assumes both design ends, freeze_if and freeze_assertions compiled first
`default_nettype none
`include "freeze_cfg.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  num_errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 500) begin \
  @(negedge core_clk); n++; end if (n >= 500) num_errors++; end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic             core_clk, sys_rst, want, hk_done, tck, tms, hk_req;
  logic             glob_lvl, clk_en, user_rst_n, tck_hold;
  logic [`IO_W-1:0] pad_in, async_in, pad_out, core_in, async_out;
  logic [3:0]       tap;
  int               num_errors = 0;
  int               compares = 0;
  int               n;

  freeze_if link ();
  low_static_access_macro low_static_access_macro_inst (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst), .link(link),
    .pad_in_i(pad_in), .tck_i(tck), .tms_i(tms), .pad_out_o(pad_out),
    .core_in_o(core_in), .global_o(glob_lvl), .tap_state_o(tap));
  freeze_mgmt freeze_mgmt_inst (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst), .link(link),
    .freeze_want_i(want), .housekeep_done_i(hk_done),
    .async_in_i(async_in), .clk_en_o(clk_en), .housekeep_req_o(hk_req),
    .async_out_o(async_out), .user_rst_n_o(user_rst_n),
    .tck_hold_o(tck_hold));
  freeze_assertions freeze_assertions_inst (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst),
    .freeze_pin_allow(link.freeze_pin_allow),
    .freeze_pin(link.freeze_pin), .frozen(link.frozen),
    .inputs_en(link.inputs_en), .outputs_en(link.outputs_en),
    .self_rst_pin(link.self_rst_pin));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // test clock runs only while management lets it, so it is static frozen
  always @(negedge core_clk) begin
    if (tck_hold !== 1'b1) tck <= ~tck;
  end

  task finish_test;
    $display("counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // one entry and exit, with inputs moved while frozen
  // ------------------------------------------------------------
  task freeze_round(input logic [7:0] pat);
    logic [7:0] core_s, async_s;
    logic [3:0] tap_s;
    pad_in = pat;
    async_in = pat;
    want = 1'b1;
    `WAIT(hk_req === 1'b1)
    `CHK("clk_en hk", 1'b1, clk_en)
    hk_done = 1'b1;
    `WAIT(clk_en === 1'b0)
    `CHK("allow early", 1'b0, link.freeze_pin_allow)
    async_s = async_out;
    `CHK("async_out in", pat, async_s)
    `WAIT(link.freeze_pin_allow === 1'b1)
    hk_done = 1'b0;
    link.freeze_pin = 1'b1;
    `WAIT(link.frozen === 1'b1)
    core_s = core_in;
    tap_s = tap;
    pad_in = ~pat;
    async_in = ~pat;
    repeat (10) @(negedge core_clk);
    `CHK("pad_out frz", 8'hFF, pad_out)
    `CHK("global frz", 1'b1, glob_lvl)
    `CHK("core_in frz", core_s, core_in)
    `CHK("async_out", async_s, async_out)
    `CHK("tap frz", tap_s, tap)
    `CHK("self_rst", 1'b1, link.self_rst_pin)
    `CHK("user_rst_n", 1'b0, user_rst_n)
    `CHK("tck_hold", 1'b1, tck_hold)
    want = 1'b0;
    link.freeze_pin = 1'b0;
    `WAIT(link.inputs_en === 1'b1)
    n = 0;
    while (link.outputs_en !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("out lag", `OUT_LAG_CYC, n)
    // pads and globals follow the output enable one edge later
    @(negedge core_clk);
    `CHK("pad_out run", pat, pad_out)
    `CHK("clk_en gated", 1'b0, clk_en)
    `CHK("core_in run", ~pat, core_in)
    `CHK("global run", 1'b0, glob_lvl)
    `CHK("user_rst_n run", 1'b1, user_rst_n)
    `WAIT(clk_en === 1'b1)
    `CHK("clk_en run", 1'b1, clk_en)
    $display("test freeze round done");
  endtask : freeze_round

  initial begin
    #20000;
    num_errors++;
    finish_test();
  end

  initial begin
    sys_rst = 1'b1;
    {want, hk_done, tck, tms} = 4'h0;
    pad_in = 8'h00;
    async_in = 8'h00;
    link.freeze_pin = 1'b0;
    repeat (20) @(negedge core_clk);
    `CHK("pad_out rst", 8'hFF, pad_out)
    `CHK("core_in rst", 8'h00, core_in)
    `CHK("tap rst", 4'hF, tap)
    sys_rst = 1'b0;
    $display("test reset done");
    // pin raised with allow low must be ignored
    link.freeze_pin = 1'b1;
    repeat (20) @(negedge core_clk);
    `CHK("frozen blocked", 1'b0, link.frozen)
    `CHK("outputs_en blocked", 1'b1, link.outputs_en)
    `CHK("tap run", 4'hC, tap)
    link.freeze_pin = 1'b0;
    $display("test blocked pin done");
    for (int r = 0; r < 2; r++) freeze_round(8'h5A ^ {8{r[0]}});
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
